// ### inc/timed_serdes_io_defines.svh
// Purpose: offsets, field layouts, reset values and timing counts of the port block
// Assumes: 12-bit apb byte address, 32-bit data
// Notes: definitions only
`ifndef TIMED_SERDES_IO_DEFINES_SVH
`define TIMED_SERDES_IO_DEFINES_SVH

// ============================================================
// address map
`define REGION_PORT 4'h0
`define REGION_CLK 4'h1
`define REGION_LINK 4'h2
`define LINK_ADDR 12'h200
`define REG_CTRL 3'h0
`define REG_DATA 3'h1
`define REG_COND 3'h2
`define REG_TIME 3'h3
`define REG_COUNT 3'h4
`define REG_STAMP 3'h5
`define REG_STAT 3'h6

// ============================================================
// fields and reset values
`define CTRL_W 11
`define CTRL_RST 11'h000
`define CLK_CFG_W 9
`define CLK_CFG_RST 9'h000
`define STAT_RX_VALID 0
`define STAT_TX_FULL 1
`define STAT_EVENT 2

// ============================================================
// clocking
`define NUM_CB 6
`define XFER_W 32
`define CLOCK_KHZ 250000
`define REF_KHZ 100000

`endif

// ### inc/timed_serdes_io_pkg.sv
// Purpose: types shared by the port block and its bench
// Assumes: constants live in timed_serdes_io_defines.svh
// Notes: none
package timed_serdes_io_pkg;

  typedef enum logic [1:0] {
    COND_NONE,
    COND_EQ,
    COND_NEQ
  } cond_t;

  // bit 0 is en
  typedef struct packed {
    logic timed;
    logic strobe_out;
    logic strobe_in;
    cond_t cond;
    logic [2:0] cb;
    logic oc;
    logic out;
    logic en;
  } port_ctrl_t;

  typedef struct packed {
    logic [7:0] div;
    logic src_pin;
  } clk_cfg_t;

endpackage : timed_serdes_io_pkg

// ### logic/timed_serdes_io_port.sv
// Purpose: two timed serialising i/o ports sharing pins, with six clock blocks
// Assumes: apb slave, zero wait states; pins pass a three-stage synchroniser
// Notes: port 0 is the narrow port on the low pins, port 1 the wide port
//
// Functional notes
// - port widths 1..32, one direction per port
// - drive pins or sample, optionally on condition
// - each core access finishes in one cycle
// - open collector: drive low, float high, per port
// - data passes serdes plus transfer register
// - 16-bit counter times pin-register transfers
// - counter readable; transfers deferred to counter value
// - counter captured as timestamp on each transfer
// - enabled link takes shared pins from ports
// - enabled narrower port overrides wider on shared pins
// - unshared pins stay with the wider port
// - port always transfers at its own width
// - six clock blocks; block zero is reference
// - other clock blocks run at programmable rates
// - clock block may use 1-bit port as clock
// - clock from 1-bit port optionally divided
// - accept strobe in, generate strobe out
// - after reset every port uses block zero
// - pin events delivered directly to the tile
//
// The implementer's own choices: the address map and the APB register port.
`include "timed_serdes_io_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module timed_serdes_io_port #(
  parameter int NARROW_W = 1,
  parameter int WIDE_W = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WIDE_W-1:0] pin_in,
  output logic [WIDE_W-1:0] pin_out,
  output logic [WIDE_W-1:0] pin_oe_n,
  input wire logic [1:0] strobe_in_qualifier,
  output logic [1:0] strobe_out_qualifier,
  output logic [1:0] port_event
);

  // port 0 is the narrow port, port 1 the wide port; both share the low pins
  localparam int NPORT = 2;
  // synchronised word: pins in the low bits, one strobe per port above them
  localparam int SW = WIDE_W + NPORT;

  // ============================================================
  // decode helpers
  function automatic logic hit_port(input logic [11:0] a, input int p, input logic [2:0] r);
    return a[11:8] == `REGION_PORT && a[7:5] == 3'(p) && a[4:2] == r;
  endfunction : hit_port

  function automatic logic hit_clk(input logic [11:0] a, input int c);
    return a[11:8] == `REGION_CLK && a[7:5] == 3'h0 && a[4:2] == 3'(c);
  endfunction : hit_clk

  // ============================================================
  // apb slave
  logic [31:0] next_rdata;
  logic next_err;
  logic err_q;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] port_rd [NPORT];
  timed_serdes_io_pkg::clk_cfg_t cb_cfg [`NUM_CB];
  logic [WIDE_W-1:0] link_dis;

  // zero wait states keep every core access to one cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign wr_ok = psel & penable & pwrite & ~err_q;
  assign rd_ok = psel & penable & ~pwrite & ~err_q;

  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    case (paddr[11:8])
      `REGION_PORT: begin
        if (paddr[7:5] < 3'(NPORT) && paddr[4:2] <= `REG_STAT && paddr[1:0] == 2'h0) begin
          next_rdata = port_rd[paddr[5]];
        end else begin
          next_err = 1'b1;
        end
      end
      `REGION_CLK: begin
        if (paddr[7:5] == 3'h0 && paddr[4:2] < 3'(`NUM_CB) && paddr[1:0] == 2'h0) begin
          next_rdata = 32'(cb_cfg[paddr[4:2]]);
        end else begin
          next_err = 1'b1;
        end
      end
      `REGION_LINK: begin
        if (paddr == `LINK_ADDR) begin
          next_rdata = 32'(link_dis);
        end else begin
          next_err = 1'b1;
        end
      end
      default: next_err = 1'b1;
    endcase
  end

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= '0;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= next_rdata;
      err_q <= next_err;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      link_dis <= '0;
    end else if (wr_ok && paddr == `LINK_ADDR) begin
      link_dis <= pwdata[WIDE_W-1:0];
    end
  end

  // ============================================================
  // pin synchroniser
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] pins;
  logic clk_pin_q;
  logic pin_rise;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pins <= '0;
      clk_pin_q <= 1'b0;
    end else begin
      sync1 <= {strobe_in_qualifier, pin_in};
      sync2 <= sync1;
      sync3 <= sync2;
      // a bit only moves once two stages agree
      pins <= (sync2 & ~(sync2 ^ sync3)) | (pins & (sync2 ^ sync3));
      clk_pin_q <= pins[0];
    end
  end

  // pin 0 is the 1-bit port usable as an application clock
  // limitation: an external clock above a quarter of the system clock is missed
  assign pin_rise = pins[0] & ~clk_pin_q;

  // ============================================================
  // clock blocks
  logic [31:0] ref_acc;
  logic ref_tick;
  logic [`NUM_CB-1:0] cb_tick;

  // fractional step: reference ticks at its own rate on the fast clock
  assign ref_tick = (ref_acc + 32'(`REF_KHZ)) >= 32'(`CLOCK_KHZ);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ref_acc <= '0;
    end else if (ref_tick) begin
      ref_acc <= ref_acc + 32'(`REF_KHZ) - 32'(`CLOCK_KHZ);
    end else begin
      ref_acc <= ref_acc + 32'(`REF_KHZ);
    end
  end

  assign cb_tick[0] = ref_tick;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cb_cfg[0] <= `CLK_CFG_RST;
    end
  end

  for (genvar c = 1; c < `NUM_CB; c++) begin : g_cb
    logic [7:0] div_cnt;
    logic src_edge;

    assign src_edge = cb_cfg[c].src_pin ? pin_rise : ref_tick;
    assign cb_tick[c] = src_edge && div_cnt == cb_cfg[c].div;

    always_ff @(posedge clock) begin
      if (!reset_n) begin
        cb_cfg[c] <= `CLK_CFG_RST;
      end else if (wr_ok && hit_clk(paddr, c)) begin
        cb_cfg[c] <= timed_serdes_io_pkg::clk_cfg_t'(pwdata[`CLK_CFG_W-1:0]);
      end
    end

    always_ff @(posedge clock) begin
      if (!reset_n) begin
        div_cnt <= '0;
      end else if (src_edge) begin
        div_cnt <= (div_cnt == cb_cfg[c].div) ? 8'h00 : div_cnt + 8'h01;
      end
    end
  end

  // ============================================================
  // ports
  timed_serdes_io_pkg::port_ctrl_t ctrl [NPORT];
  logic [31:0] oval [NPORT];
  logic evt [NPORT];
  logic sout [NPORT];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam int W = (p == 0) ? NARROW_W : WIDE_W;
    localparam int K = `XFER_W / W;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] cond;
    logic [31:0] sh;
    logic [31:0] sh_in;
    logic [15:0] ttime;
    logic [15:0] cnt;
    logic [15:0] stamp;
    logic [5:0] left;
    logic tx_full;
    logic rx_valid;
    logic tick;
    logic at_time;
    logic cmatch;
    logic qual;
    logic [W-1:0] samp;

    assign tick = ctrl[p].en && ctrl[p].cb < 3'(`NUM_CB) && cb_tick[ctrl[p].cb];
    assign at_time = !ctrl[p].timed || cnt == ttime;
    assign samp = pins[W-1:0];
    assign qual = !ctrl[p].strobe_in || pins[WIDE_W + p];
    // deserialiser fills from the top so the first sample ends lowest
    assign sh_in = (sh >> W) | (32'(samp) << (`XFER_W - W));

    always_comb begin
      case (ctrl[p].cond)
        timed_serdes_io_pkg::COND_EQ: cmatch = samp == cond[W-1:0];
        timed_serdes_io_pkg::COND_NEQ: cmatch = samp != cond[W-1:0];
        default: cmatch = 1'b1;
      endcase
    end

    always_comb begin
      case (paddr[4:2])
        `REG_CTRL: port_rd[p] = 32'(ctrl[p]);
        `REG_DATA: port_rd[p] = rx;
        `REG_COND: port_rd[p] = cond;
        `REG_TIME: port_rd[p] = 32'(ttime);
        `REG_COUNT: port_rd[p] = 32'(cnt);
        `REG_STAMP: port_rd[p] = 32'(stamp);
        `REG_STAT: port_rd[p] = {29'h0, evt[p], tx_full, rx_valid};
        default: port_rd[p] = '0;
      endcase
    end

    always_ff @(posedge clock) begin
      if (!reset_n) begin
        ctrl[p] <= `CTRL_RST;
        cond <= '0;
        ttime <= '0;
      end else if (wr_ok) begin
        if (hit_port(paddr, p, `REG_CTRL)) begin
          ctrl[p] <= timed_serdes_io_pkg::port_ctrl_t'(pwdata[`CTRL_W-1:0]);
        end
        if (hit_port(paddr, p, `REG_COND)) begin
          cond <= pwdata;
        end
        if (hit_port(paddr, p, `REG_TIME)) begin
          ttime <= pwdata[15:0];
        end
      end
    end

    // free-running on the port clock, wraps at 16 bits
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        cnt <= '0;
      end else if (tick) begin
        cnt <= cnt + 16'h0001;
      end
    end

    always_ff @(posedge clock) begin
      if (!reset_n) begin
        tx <= '0;
        rx <= '0;
        sh <= '0;
        left <= '0;
        oval[p] <= '0;
        tx_full <= 1'b0;
        rx_valid <= 1'b0;
        evt[p] <= 1'b0;
        sout[p] <= 1'b0;
        stamp <= '0;
      end else if (ctrl[p].out) begin
        if (tick) begin
          sout[p] <= 1'b0;
        end
        if (tick && left != 6'h00) begin
          oval[p] <= 32'(sh[W-1:0]);
          sh <= sh >> W;
          left <= left - 6'h01;
          sout[p] <= ctrl[p].strobe_out;
        end else if (tick && tx_full && at_time) begin
          oval[p] <= 32'(tx[W-1:0]);
          sh <= tx >> W;
          left <= 6'(K - 1);
          tx_full <= 1'b0;
          stamp <= cnt;
          sout[p] <= ctrl[p].strobe_out;
        end
        // a new word written while the old one loads is kept
        if (wr_ok && hit_port(paddr, p, `REG_DATA)) begin
          tx <= pwdata;
          tx_full <= 1'b1;
        end
      end else begin
        sout[p] <= 1'b0;
        if (rd_ok && hit_port(paddr, p, `REG_DATA)) begin
          rx_valid <= 1'b0;
          evt[p] <= 1'b0;
        end
        // set after clear, so a word arriving in the same cycle as the read clear is not lost
        if (tick && qual && (left != 6'h00 || (at_time && cmatch))) begin
          if (left == 6'(K - 1) || ctrl[p].cond != timed_serdes_io_pkg::COND_NONE) begin
            rx <= (ctrl[p].cond != timed_serdes_io_pkg::COND_NONE) ? 32'(samp) : sh_in;
            rx_valid <= 1'b1;
            evt[p] <= 1'b1;
            stamp <= cnt;
            left <= '0;
          end else begin
            sh <= sh_in;
            left <= left + 6'h01;
          end
        end
      end
    end

    assign port_event[p] = evt[p];
    assign strobe_out_qualifier[p] = sout[p];
  end

  // ============================================================
  // pin ownership and drive
  // ownership is decided per pin, so a narrow port steals only its own pins
  // and the wide port keeps shifting its full word underneath
  for (genvar i = 0; i < WIDE_W; i++) begin : g_pin
    logic own0;
    logic bitv;
    logic drive;
    logic oc;

    assign own0 = (i < NARROW_W) && ctrl[0].en;
    // pins the narrow port does not own fall to the wide port
    assign bitv = own0 ? oval[0][i] : oval[1][i];
    assign oc = own0 ? ctrl[0].oc : ctrl[1].oc;
    assign drive = (own0 ? ctrl[0].out : (ctrl[1].en && ctrl[1].out)) && !link_dis[i];
    assign pin_out[i] = oc ? 1'b0 : bitv;
    assign pin_oe_n[i] = !(drive && (!oc || !bitv));
  end

endmodule : timed_serdes_io_port

`default_nettype wire

// ### sim/pin_world.sv
// Purpose: pins outside the device, pull-downs and an external driver
// Assumes: the bench never drives a pin the device owns
// Notes: released pins fall to the pull-down level while the external driver is off
`timescale 1ns/100ps
`default_nettype none

module pin_world #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe_n,
  input wire logic ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_level
);
  // ==========
  // wire resolution; no contention model, so overlap goes unseen
  always_comb begin
    pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & {W{ext_en}} & ext_val);
  end
endmodule : pin_world
`default_nettype wire

// ### sim/tb_timed_serdes_io_port.sv
// Purpose: self-checking bench of the port block
// Assumes: reference tick 2 of every 5 clocks, zero-wait apb
// Notes: wide output compared as a stream of pin changes
`timescale 1ns/100ps
`default_nettype none

module tb_timed_serdes_io_port;
  // ==========
  // stimulus and model state
  logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, c, d;
  logic pready, pslverr, e, ext_en = 1'b0;
  logic [7:0] pin_level, pin_out, pin_oe_n, b, last, ext_val = 8'h00;
  logic [1:0] strobe_in = 2'b00, port_event, strobe_out;
  int so_cnt = 0;
  logic [7:0] q[$], got[$];
  int n_fail = 0, total_checks = 0, cyc = 0, seed = 7127;
  bit watch = 1'b0, hit, lo, hz;
  always #2 clock = ~clock;
  timed_serdes_io_port i_timed_serdes_io_port (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .strobe_in_qualifier(strobe_in), .strobe_out_qualifier(strobe_out), .port_event(port_event));
  pin_world i_pin_world (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_level(pin_level));

  task automatic close_out();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    total_checks++;
    if (y !== x) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, x, y);
    end
  endtask : chk

  // one idle edge after each transfer keeps psel from two writes in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, r);
  endtask : rd

  task automatic wait_ev(input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge clock);
      hit = port_event[1] === 1'b1;
    end
    @(posedge clock);
  endtask : wait_ev

  always @(negedge clock) begin
    cyc++;
    if (watch && strobe_out[1] === 1'b1) so_cnt++;
    if (watch && pin_out !== last) begin
      got.push_back(pin_out);
      last = pin_out;
    end
    if (cyc > 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ==========
  // scenarios
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk("idle oe", 32'hff, {24'h0, pin_oe_n});
    rd(12'h000, 32'h0);
    wr_rd: begin
      apb(1'b1, 12'h100, 32'h1ff);
      rd(12'h100, 32'h0);
      apb(1'b1, 12'h104, 32'h1fe);
      rd(12'h104, 32'h1fe);
    end
    rd(12'h300, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("registers done");
    apb(1'b1, 12'h020, 32'h203);
    chk("wide oe", 32'h0, {24'h0, pin_oe_n});
    d = $random(seed);
    b = pin_out;
    last = pin_out;
    for (int i = 0; i < 4; i++) begin
      if (d[8*i+:8] !== b) q.push_back(d[8*i+:8]);
      b = d[8*i+:8];
    end
    watch = 1'b1;
    apb(1'b1, 12'h024, d);
    repeat (60) @(posedge clock);
    watch = 1'b0;
    chk("slices", 32'(q.size()), 32'(got.size()));
    // four back-to-back slices hold the strobe for four ticks, ten clocks
    chk("strobe out", 32'd10, 32'(so_cnt));
    foreach (q[i]) if (i < got.size()) chk("slice", 32'(q[i]), 32'(got[i]));
    apb(1'b0, 12'h030, 32'h0);
    c = r;
    repeat (47) @(posedge clock);
    apb(1'b0, 12'h030, 32'h0);
    chk("count step", {16'h0, c[15:0] + 16'd20}, r);
    $display("output done");
    apb(1'b1, 12'h000, 32'h007);
    chk("upper oe", 32'h0, {25'h0, pin_oe_n[7:1]});
    apb(1'b1, 12'h004, 32'h0000ffff);
    lo = 1'b0;
    hz = 1'b0;
    repeat (120) begin
      @(negedge clock);
      if (pin_oe_n[0] === 1'b1) hz = 1'b1;
      if (hz && pin_oe_n[0] === 1'b0) lo = 1'b1;
    end
    @(posedge clock);
    chk("float", 32'h1, {31'h0, hz});
    chk("low after float", 32'h1, {31'h0, lo});
    apb(1'b1, 12'h200, 32'h1);
    chk("link oe", 32'h1, {31'h0, pin_oe_n[0]});
    apb(1'b1, 12'h200, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h020, 32'h0);
    $display("sharing done");
    b = $random(seed);
    ext_val <= b;
    ext_en <= 1'b1;
    repeat (8) @(posedge clock);
    apb(1'b1, 12'h020, 32'h001);
    wait_ev(300);
    apb(1'b0, 12'h034, 32'h0);
    c = r;
    apb(1'b0, 12'h030, 32'h0);
    chk("event", 32'h1, {31'h0, hit});
    chk("stamp age", 32'h1, {31'h0, r[15:0] - c[15:0] < 16'd8});
    rd(12'h024, {4{b}});
    apb(1'b1, 12'h020, 32'h0);
    // modes equal then not-equal; first level never fires, second does
    for (int m = 1; m <= 2; m++) begin
      apb(1'b1, 12'h028, {24'h0, b ^ 8'h5a});
      ext_val <= (m == 1) ? b : b ^ 8'h5a;
      apb(1'b0, 12'h024, 32'h0);
      apb(1'b1, 12'h020, 32'(m * 64 + 1));
      wait_ev(100);
      chk("cond idle", 32'h0, {31'h0, hit});
      ext_val <= (m == 1) ? b ^ 8'h5a : b;
      wait_ev(300);
      chk("cond hit", 32'h1, {31'h0, hit});
      rd(12'h024, {24'h0, (m == 1) ? b ^ 8'h5a : b});
      apb(1'b1, 12'h020, 32'h0);
    end
    $display("input done");
    apb(1'b0, 12'h024, 32'h0);
    apb(1'b1, 12'h020, 32'h101);
    wait_ev(100);
    chk("strobe idle", 32'h0, {31'h0, hit});
    strobe_in <= 2'b10;
    wait_ev(300);
    chk("strobe hit", 32'h1, {31'h0, hit});
    rd(12'h024, {4{b}});
    $display("strobe done");
    close_out();
  end
endmodule : tb_timed_serdes_io_port
`default_nettype wire

// ### sim/timed_serdes_io_monitor.sv
// Purpose: port-level checks of the port block
// Assumes: zero-wait apb, byte map of the hand-over
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none

module timed_serdes_io_monitor #(
  parameter int WIDE_W = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WIDE_W-1:0] pin_out,
  input wire logic [WIDE_W-1:0] pin_oe_n,
  input wire logic [1:0] strobe_out_qualifier,
  input wire logic [1:0] port_event
);
  // ==========
  // shadow of the control bits the checks lean on
  logic oc0;
  logic link0;
  wire logic wr = psel && penable && pwrite;
  wire logic rd1 = psel && penable && !pwrite && paddr == 12'h024;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      oc0 <= 1'b0;
    end else if (wr && paddr == 12'h000) begin
      oc0 <= pwdata[2:0] == 3'b111;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      link0 <= 1'b0;
    end else if (wr && paddr == 12'h200) begin
      link0 <= pwdata[0];
    end
  end
  // ==========
  // assertions
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_nodata: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on refused access");
  a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved");
  a_oc_low_only: assert property (oc0 && !pin_oe_n[0] |-> !pin_out[0])
    else $error("open collector drove high");
  a_link_frees: assert property (link0 |-> pin_oe_n[0])
    else $error("shared pin still driven");
  a_event_sticky: assert property (port_event[1] && !rd1 |=> port_event[1])
    else $error("event lost unread");
  a_reset_idle: assert property ($rose(reset_n) |-> pin_oe_n == '1 && port_event == 2'b00
    && strobe_out_qualifier == 2'b00)
    else $error("not idle after reset");
endmodule : timed_serdes_io_monitor

bind timed_serdes_io_port timed_serdes_io_monitor #(.WIDE_W(WIDE_W)) i_mon (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .strobe_out_qualifier(strobe_out_qualifier),
  .port_event(port_event));
`default_nettype wire
